// ---- rtl/ibrk_ctrl.sv ----
// Instruction break controller: channels, flags and user break request
`timescale 1ns/1ps
`default_nettype none
module ibrk_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic standby,
    input wire ibrk_pkg::ibrk_cfg_t cfg0,
    input wire ibrk_pkg::ibrk_cfg_t cfg1,
    input wire logic cpu_valid,
    input wire logic [ibrk_pkg::IBRK_AW-1:0] cpu_addr,
    input wire logic cpu_ifetch,
    input wire logic cpu_upper32,
    input wire logic cpu_delay_slot,
    input wire logic insn_retire,
    input wire logic insn_halted,
    input wire logic insn_divide,
    input wire logic exc_valid,
    input wire logic [ibrk_pkg::IBRK_PW-1:0] exc_prio,
    input wire logic sys_valid,
    input wire logic [ibrk_pkg::IBRK_AW-1:0] sys_addr,
    input wire logic [ibrk_pkg::IBRK_DW-1:0] sys_data,
    input wire logic sys_write,
    input wire logic [ibrk_pkg::IBRK_CHANNELS-1:0] flag_clr,
    input wire logic ub_ack,
    output logic [ibrk_pkg::IBRK_CHANNELS-1:0] match_flag,
    output logic ub_req
);
    import ibrk_pkg::*;

    // ------------------------------------------------------------
    // Channel comparators
    // ------------------------------------------------------------
    ibrk_match_if mif ();
    ibrk_cfg_t cfg [IBRK_CHANNELS];   // Per-channel configuration
    assign cfg[0] = cfg0;
    assign cfg[1] = cfg1;

    genvar gi;
    generate
        for (gi = 0; gi < IBRK_CHANNELS; gi++) begin : g_chan
            ibrk_chan_match u_match (
                .cfg(cfg[gi]),
                .cpu_valid(cpu_valid),
                .cpu_addr(cpu_addr),
                .cpu_ifetch(cpu_ifetch),
                .cpu_upper32(cpu_upper32),
                .sys_valid(sys_valid),
                .sys_addr(sys_addr),
                .sys_data(sys_data),
                .sys_write(sys_write),
                .pre_hit(mif.pre_hit[gi]),
                .post_hit(mif.post_hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Qualified events
    // ------------------------------------------------------------
    logic [IBRK_CHANNELS-1:0] post_pend_q; // Post hits awaiting retire
    logic [IBRK_CHANNELS-1:0] pre_ev;
    logic [IBRK_CHANNELS-1:0] post_ev;
    logic exc_wins;          // Exception at or above user break priority present
    logic any_ev;

    // A pre-break in a delay slot is suppressed so no request
    // lands in front of the branch target
    always_comb begin
        exc_wins = exc_valid && (exc_prio > IBRK_UB_PRIO - 4'h1);
        pre_ev = mif.pre_hit & {IBRK_CHANNELS{!cpu_delay_slot}};
        // Retire or halt both complete a post-break, so a halted
        // divide still breaks; the pending pre-break of the next
        // instruction is already captured by its own fetch match
        post_ev = post_pend_q & {IBRK_CHANNELS{insn_retire || insn_halted}};
        if (standby) begin
            pre_ev = '0;
            post_ev = '0;
        end
        any_ev = |(pre_ev | post_ev);
    end

    // ------------------------------------------------------------
    // Post-break pending capture
    // ------------------------------------------------------------
    // Channels are tracked independently, so mixed pre/post on one
    // address may leave both flags set; software avoids that case
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            post_pend_q <= '0;
        end else if (standby) begin
            post_pend_q <= '0;
        end else begin
            post_pend_q <= (post_pend_q & ~post_ev) | mif.post_hit;
        end
    end

    // ------------------------------------------------------------
    // Condition-match flags
    // ------------------------------------------------------------
    // Set wins over clear so a fresh event is never lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_flag <= '0;
        end else begin
            match_flag <= (match_flag & ~flag_clr) | pre_ev | post_ev;
        end
    end

    // ------------------------------------------------------------
    // Request state machine
    // ------------------------------------------------------------
    ibrk_state_t state_q;
    // Divide halt with a pending pre-break on the next insn still
    // raises: the pre event comes from the fetch, not completion
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IBRK_ST_IDLE;
        end else begin
            case (state_q)
                IBRK_ST_IDLE: begin
                    if (any_ev && !exc_wins) begin
                        state_q <= IBRK_ST_REQ;
                    end else if (|post_pend_q && insn_divide) begin
                        state_q <= IBRK_ST_PEND;
                    end
                end
                IBRK_ST_PEND: begin
                    if (standby) begin
                        state_q <= IBRK_ST_IDLE;
                    end else if (any_ev && !exc_wins) begin
                        state_q <= IBRK_ST_REQ;
                    end else if (!(|post_pend_q)) begin
                        state_q <= IBRK_ST_IDLE;
                    end
                end
                IBRK_ST_REQ: begin
                    if (ub_ack || standby) begin
                        state_q <= IBRK_ST_IDLE;
                    end
                end
                default: state_q <= IBRK_ST_IDLE;
            endcase
        end
    end

    // Request is a registered level until acknowledged or standby
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ub_req <= 1'b0;
        end else begin
            ub_req <= (state_q == IBRK_ST_REQ) && !ub_ack && !standby
                || ((state_q != IBRK_ST_REQ) && any_ev && !exc_wins);
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ibrk_pkg.sv ----
// Package of constants and types for the instruction break controller
package ibrk_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int IBRK_CHANNELS = 2;      // Number of break channels
    localparam int IBRK_AW = 32;           // Address width
    localparam int IBRK_DW = 32;           // Data width
    localparam int IBRK_PW = 4;            // Exception priority width
    // User break interrupt priority level
    localparam logic [IBRK_PW-1:0] IBRK_UB_PRIO = 4'hF;
    localparam logic [IBRK_AW-1:0] IBRK_ADDR_RST = 32'h00000000;
    localparam logic [IBRK_AW-1:0] IBRK_MASK_RST = 32'h00000000;
    localparam logic [IBRK_DW-1:0] IBRK_DATA_RST = 32'h00000000;
    localparam logic [IBRK_AW-1:0] IBRK_HALF = 32'h00000002; // Halfword step
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        IBRK_BUS_CPU = 1'b0,   // Instruction-side processor bus
        IBRK_BUS_SYS = 1'b1    // Internal system bus
    } ibrk_bus_t;
    typedef enum logic [0:0] {
        IBRK_WHEN_PRE  = 1'b0, // Before execution
        IBRK_WHEN_POST = 1'b1  // After execution
    } ibrk_when_t;
    typedef enum logic [1:0] {
        IBRK_RW_ANY   = 2'h0,
        IBRK_RW_READ  = 2'h1,
        IBRK_RW_WRITE = 2'h2,
        IBRK_RW_NONE  = 2'h3
    } ibrk_rw_t;
    typedef enum logic [1:0] {
        IBRK_ST_IDLE = 2'b00,  // No break pending
        IBRK_ST_PEND = 2'b01,  // Post break waits for retire
        IBRK_ST_REQ  = 2'b10   // Request raised
    } ibrk_state_t;
    typedef struct packed {
        logic enable;
        ibrk_bus_t bus;
        ibrk_when_t when_sel;
        ibrk_rw_t rw;
        logic ifetch;          // Match instruction fetch only
        logic data_en;         // Compare data as well
        logic [IBRK_AW-1:0] addr;
        logic [IBRK_AW-1:0] mask; // 1 bits are ignored
        logic [IBRK_DW-1:0] data;
    } ibrk_cfg_t;
endpackage

// ---- rtl/ibrk_match_if.sv ----
// Interface carrying per-channel match results to the controller core
`timescale 1ns/1ps
`default_nettype none
interface ibrk_match_if;
    import ibrk_pkg::*;
    logic [IBRK_CHANNELS-1:0] pre_hit;   // Pre-execution match
    logic [IBRK_CHANNELS-1:0] post_hit;  // Post-execution match
    modport src (output pre_hit, output post_hit);
    modport dst (input pre_hit, input post_hit);
endinterface
`default_nettype wire

// ---- rtl/ibrk_chan_match.sv ----
// One break channel comparator over its selected bus
`timescale 1ns/1ps
`default_nettype none
module ibrk_chan_match
    import ibrk_pkg::*;
(
    input wire ibrk_pkg::ibrk_cfg_t cfg,
    input wire logic cpu_valid,
    input wire logic [IBRK_AW-1:0] cpu_addr,
    input wire logic cpu_ifetch,
    input wire logic cpu_upper32,
    input wire logic sys_valid,
    input wire logic [IBRK_AW-1:0] sys_addr,
    input wire logic [IBRK_DW-1:0] sys_data,
    input wire logic sys_write,
    output logic pre_hit,
    output logic post_hit
);
    // ------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------
    logic on_cpu;   // Selected bus is the processor bus
    logic hit;      // Raw condition match
    logic lower_half; // Address names low half of 32-bit insn
    logic rw_ok;
    always_comb begin
        // Only one bus per channel, never both
        on_cpu = (cfg.bus == IBRK_BUS_CPU);
        rw_ok = 1'b1;
        case (cfg.rw)
            IBRK_RW_READ: rw_ok = !sys_write;
            IBRK_RW_WRITE: rw_ok = sys_write;
            IBRK_RW_NONE: rw_ok = 1'b0;
            default: rw_ok = 1'b1;
        endcase
        if (on_cpu) begin
            hit = cpu_valid && (cfg.ifetch == cpu_ifetch)
                && (((cpu_addr ^ cfg.addr) & ~cfg.mask) == IBRK_ADDR_RST);
            // Fetch addr is upper half; config addr one half above
            lower_half = cpu_upper32 && !cpu_ifetch ? 1'b0 :
                (cpu_upper32
                 && (((cpu_addr + IBRK_HALF) ^ cfg.addr) & ~cfg.mask) == IBRK_ADDR_RST);
        end else begin
            hit = sys_valid && rw_ok
                && (((sys_addr ^ cfg.addr) & ~cfg.mask) == IBRK_ADDR_RST)
                && (!cfg.data_en || sys_data == cfg.data);
            lower_half = 1'b0;
        end
        if (!cfg.enable) begin
            hit = 1'b0;
            lower_half = 1'b0;
        end
        // Lower-halfword pre-break is treated as a post-break
        pre_hit = hit && on_cpu && (cfg.when_sel == IBRK_WHEN_PRE);
        post_hit = (hit && (cfg.when_sel == IBRK_WHEN_POST || !on_cpu))
            || (lower_half && cpu_valid && cfg.when_sel == IBRK_WHEN_PRE);
    end
endmodule
`default_nettype wire

// ---- tb/ibrk_props.sv ----
// Port checker for the instruction break controller
`timescale 1ns/1ps
`default_nettype none
module ibrk_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic standby,
    input wire ibrk_pkg::ibrk_cfg_t cfg0,
    input wire ibrk_pkg::ibrk_cfg_t cfg1,
    input wire logic cpu_valid,
    input wire logic [ibrk_pkg::IBRK_AW-1:0] cpu_addr,
    input wire logic cpu_ifetch,
    input wire logic cpu_upper32,
    input wire logic cpu_delay_slot,
    input wire logic insn_retire,
    input wire logic insn_halted,
    input wire logic insn_divide,
    input wire logic exc_valid,
    input wire logic [ibrk_pkg::IBRK_PW-1:0] exc_prio,
    input wire logic sys_valid,
    input wire logic ub_ack,
    input wire logic [ibrk_pkg::IBRK_CHANNELS-1:0] match_flag,
    input wire logic ub_req
);
    import ibrk_pkg::*;
    // ----------------------------------------
    // Plain processor-bus hits
    // ----------------------------------------
    logic pre0;
    logic post1;
    logic quiet; // Nothing else may raise the request
    function automatic logic hit(ibrk_cfg_t c, ibrk_when_t w);
        return c.enable && c.bus == IBRK_BUS_CPU && c.when_sel == w && c.rw == IBRK_RW_ANY
            && !c.data_en && (cpu_ifetch || !c.ifetch) && cpu_valid && !cpu_upper32
            && cpu_addr == c.addr && !standby;
    endfunction
    // always_comb so reads inside the function are seen
    always_comb begin
        pre0 = hit(cfg0, IBRK_WHEN_PRE);
        post1 = hit(cfg1, IBRK_WHEN_POST) && !insn_retire && !insn_halted;
        quiet = !ub_req && !cfg1.enable && !insn_retire && !insn_halted;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_post1; post1; endsequence
    sequence s_halt_div; insn_halted && insn_divide && !exc_valid && !standby; endsequence
    property p_pre; pre0 && !cpu_delay_slot && !exc_valid |=> ub_req && match_flag[0]; endproperty
    a_pre: assert property (p_pre) else $error("pre hit not flagged");
    property p_exc; pre0 && exc_valid && exc_prio == IBRK_UB_PRIO && quiet |=> !ub_req; endproperty
    a_exc: assert property (p_exc) else $error("break not dropped");
    property p_slot; pre0 && cpu_delay_slot && quiet |=> !ub_req; endproperty
    a_slot: assert property (p_slot) else $error("delay slot break");
    property p_stby; $rose(ub_req) |-> !$past(standby); endproperty
    a_stby: assert property (p_stby) else $error("break in standby");
    property p_hold; ub_req && !ub_ack && !standby |=> ub_req; endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_ack; ub_req && ub_ack && !cpu_valid && !sys_valid && !cfg1.enable
        && !insn_retire && !insn_halted |=> !ub_req; endproperty
    a_ack: assert property (p_ack) else $error("request not dropped");
    property p_sys; cfg0.enable && cfg0.bus == IBRK_BUS_SYS && cpu_valid && quiet |=> !ub_req;
    endproperty
    a_sys: assert property (p_sys) else $error("wrong bus watched");
    property p_div; s_post1 ##1 s_halt_div |=> ub_req && match_flag[1]; endproperty
    a_div: assert property (p_div) else $error("halted divide no break");
endmodule
bind ibrk_ctrl ibrk_props u_ibrk_props (.*);
`default_nettype wire

// ---- tb/ibrk_core_model.sv ----
// Behavioural processor core issuing instructions and taking user breaks
`timescale 1ns/1ps
`default_nettype none
module ibrk_core_model (
    input wire logic ref_clk,
    input wire logic ub_req,
    output logic cpu_valid,
    output logic [ibrk_pkg::IBRK_AW-1:0] cpu_addr,
    output logic cpu_ifetch,
    output logic cpu_upper32,
    output logic cpu_delay_slot,
    output logic insn_retire,
    output logic insn_halted,
    output logic insn_divide,
    output logic exc_valid,
    output logic [ibrk_pkg::IBRK_PW-1:0] exc_prio,
    output logic ub_ack
);
    import ibrk_pkg::*;
    logic ack_en = 1'b0; // Core willing to take the break
    int ack_wait = 0; // Slow core dawdles this long
    int wait_cnt = 0;
    // Fetch only; no sleep or level-15 handler code is run
    initial begin
        {cpu_valid, cpu_upper32, cpu_delay_slot, insn_retire, insn_halted} = 5'h00;
        // The acknowledge is owned by the negedge process alone
        {insn_divide, exc_valid, cpu_ifetch} = 3'h1;
        {cpu_addr, exc_prio} = {32'hFFFFFFFF, 4'h0};
    end
    // Accept a raised break after the chosen delay
    always @(negedge ref_clk) begin
        ub_ack <= 1'b0;
        if (!ub_req || !ack_en) begin
            wait_cnt <= 0;
        end else if (!ub_ack) begin
            wait_cnt <= wait_cnt + 1;
            ub_ack <= (wait_cnt >= ack_wait);
        end
    end
    // op = {upper32, delay slot, divide, halted}; 32-bit uses upper half
    task automatic exec(input logic [IBRK_AW-1:0] a, input logic [3:0] op,
                        input logic exc, input logic [IBRK_PW-1:0] pr, output logic r1, r2);
        @(negedge ref_clk);
        {cpu_upper32, cpu_delay_slot, insn_divide} = op[3:1];
        {cpu_valid, cpu_addr, exc_valid, exc_prio} = {1'b1, a, exc, pr};
        @(negedge ref_clk);
        r1 = ub_req;
        {cpu_valid, cpu_addr, exc_valid} = {1'b0, ~a, 1'b0};
        {insn_halted, insn_retire} = {op[0], !op[0]};
        @(negedge ref_clk);
        r2 = ub_req;
        {cpu_upper32, cpu_delay_slot, insn_divide, insn_halted, insn_retire} = 5'h00;
    endtask
endmodule
`default_nettype wire

// ---- tb/ibrk_ctrl_bench.sv ----
// Self-checking bench for the break controller
`timescale 1ns/1ps
`default_nettype none
module ibrk_ctrl_bench;
    import ibrk_pkg::*;
    localparam logic [IBRK_AW-1:0] ADDR_A = 32'h00001000;
    logic ref_clk = 1'b0, rst_n = 1'b0, standby = 1'b0, r1, r2, ub_ack, ub_req;
    logic cpu_valid, cpu_ifetch, cpu_upper32, cpu_delay_slot, insn_retire, insn_halted;
    logic insn_divide, exc_valid, sys_valid = 1'b0, sys_write = 1'b0;
    logic [IBRK_AW-1:0] cpu_addr, sys_addr = 32'h0;
    logic [IBRK_DW-1:0] sys_data = 32'h0;
    logic [IBRK_PW-1:0] exc_prio;
    logic [1:0] flag_clr = 2'h0, match_flag;
    ibrk_cfg_t cfg0 = '0, cfg1 = '0; // Set a cycle before use
    int fail_count = 0, checks = 0;
    always #5 ref_clk = ~ref_clk;
    ibrk_ctrl u_ibrk_ctrl (.*);
    ibrk_core_model u_ibrk_core_model (.*);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic ibrk_cfg_t mk(ibrk_bus_t b, ibrk_when_t w, logic [IBRK_AW-1:0] a);
        return '{1'b1, b, w, IBRK_RW_ANY, b == IBRK_BUS_CPU, 1'b0, a, IBRK_MASK_RST, IBRK_DATA_RST};
    endfunction
    task automatic ck(input string n, input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Let the core accept, bounded, then clear both flags
    task automatic drain(input int w);
        u_ibrk_core_model.ack_wait <= w;
        u_ibrk_core_model.ack_en <= 1'b1;
        for (int i = 0; i < 20 && ub_req !== 1'b0; i++) @(negedge ref_clk);
        ck("ub_req", 2'h0, {1'b0, ub_req});
        if (ub_req !== 1'b0) tally_and_finish();
        u_ibrk_core_model.ack_en <= 1'b0;
        flag_clr = 2'h3;
        @(negedge ref_clk);
        flag_clr = 2'h0;
        ck("match_flag", 2'h0, match_flag);
    endtask
    task automatic t_pre;
        cfg0 = mk(IBRK_BUS_CPU, IBRK_WHEN_PRE, ADDR_A);
        u_ibrk_core_model.exec(ADDR_A, 4'h0, 1'b0, 4'h0, r1, r2);
        ck("match_flag", 2'h1, match_flag);
        drain(3);
        u_ibrk_core_model.exec(ADDR_A, 4'h0, 1'b1, 4'hE, r1, r2);
        ck("ub_req", 2'h3, {r1, r2});
        drain(0);
        u_ibrk_core_model.exec(ADDR_A, 4'h0, 1'b1, IBRK_UB_PRIO, r1, r2);
        ck("ub_req", 2'h0, {r1, r2});
        drain(0);
    endtask
    task automatic t_gate;
        u_ibrk_core_model.exec(ADDR_A, 4'h4, 1'b0, 4'h0, r1, r2);
        ck("ub_req", 2'h0, {r1, r2});
        standby = 1'b1;
        u_ibrk_core_model.exec(ADDR_A, 4'h0, 1'b0, 4'h0, r1, r2);
        ck("ub_req", 2'h0, {r1, r2});
        standby = 1'b0;
        drain(0);
    endtask
    task automatic t_post;
        cfg0 = mk(IBRK_BUS_CPU, IBRK_WHEN_PRE, ADDR_A + IBRK_HALF);
        u_ibrk_core_model.exec(ADDR_A, 4'h8, 1'b0, 4'h0, r1, r2);
        ck("ub_req", 2'h1, {r1, r2});
        drain(0);
        cfg0 = mk(IBRK_BUS_CPU, IBRK_WHEN_PRE, ADDR_A + 32'h00000004);
        cfg1 = mk(IBRK_BUS_CPU, IBRK_WHEN_POST, ADDR_A);
        u_ibrk_core_model.exec(ADDR_A, 4'h3, 1'b0, 4'h0, r1, r2);
        ck("ub_req", 2'h1, {r1, r2});
        u_ibrk_core_model.exec(ADDR_A + 32'h00000004, 4'h0, 1'b0, 4'h0, r1, r2);
        ck("match_flag", 2'h3, match_flag);
        drain(3);
    endtask
    task automatic t_sys;
        {cfg0, cfg1} = {mk(IBRK_BUS_SYS, IBRK_WHEN_PRE, ADDR_A), ibrk_cfg_t'('0)};
        u_ibrk_core_model.exec(ADDR_A, 4'h0, 1'b0, 4'h0, r1, r2);
        ck("ub_req", 2'h0, {r1, r2});
        {sys_valid, sys_write, sys_addr, sys_data} = {2'h3, ADDR_A, 32'h00005A5A};
        @(negedge ref_clk);
        {sys_valid, sys_addr, sys_data} = {1'b0, ~ADDR_A, 32'hFFFFA5A5};
        u_ibrk_core_model.exec(ADDR_A + 32'h00000010, 4'h0, 1'b0, 4'h0, r1, r2);
        ck("ub_req", 2'h1, {r1, r2});
        drain(0);
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        t_pre();
        t_gate();
        t_post();
        t_sys();
        tally_and_finish();
    end
endmodule
`default_nettype wire
